// ==== dsw_defines.vh ====
// Constants for the dual switch serial control block.
// Assumes inclusion by bare name from the design files.
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH

// ****************************************************************
// Frame layout
// ****************************************************************
`define DSW_FRAME_BITS 4'h8
`define DSW_CMD_MSB 7
`define DSW_CMD_LSB 5

// ****************************************************************
// Command codes
// ****************************************************************
`define DSW_CMD_NONE 3'h0
`define DSW_CMD_DIAG 3'h1
`define DSW_CMD_OUTCFG 3'h2
`define DSW_CMD_IOCFG 3'h3
`define DSW_CMD_RESET 3'h4
`define DSW_CMD_SLEEP 3'h5
`define DSW_CMD_WAKE 3'h6
`define DSW_CMD_CHAN 3'h7

// ****************************************************************
// Field positions within the data bits
// ****************************************************************
`define DSW_OC_OVL_B 4
`define DSW_OC_OVL_A 3
`define DSW_OC_LATCH 2
`define DSW_OC_SLEW_B 1
`define DSW_OC_SLEW_A 0
`define DSW_IO_SPI 4
`define DSW_IO_CTRL_MSB 3
`define DSW_IO_CTRL_LSB 2
`define DSW_IO_PIN_MSB 1
`define DSW_IO_PIN_LSB 0
`define DSW_CH_B 4
`define DSW_CH_A 3

// ****************************************************************
// Control and pin modes
// ****************************************************************
`define DSW_CTRL_PAR 2'h0
`define DSW_CTRL_OR 2'h1
`define DSW_CTRL_AND 2'h2
`define DSW_CTRL_SER 2'h3
`define DSW_PIN_FAULT 2'h0

// ****************************************************************
// Reset values
// ****************************************************************
`define DSW_OUTCFG_RST 5'h00
`define DSW_IOCFG_RST 5'h00
`define DSW_CHAN_RST 2'h0
`define DSW_DIAG_CLEAR 6'h3c
`define DSW_DIAG_TOP 2'h3
`define DSW_PAIR_OK 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define DSW_CLK_PERIOD_NS 8
`define DSW_WAKE_TIME_NS 100000
`define DSW_WAKE_CYCLES 16'h30d4

`endif

// ==== dsw_sync.v ====
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin level and the block clock.
`timescale 1ns/1ns
`default_nettype none

module dsw_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire rst_level,
  // Pin and filtered level
  input wire pin,
  output wire level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg hold_q;

  // Chain holds the pin relative to its idle level, so reset reads idle
  assign level_q = hold_q ^ rst_level;

  // ****************************************************************
  // Capture chain and filter
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      s1_q <= pin ^ rst_level;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        hold_q <= s3_q;
      end
    end
  end

endmodule

`default_nettype wire

// ==== dsw_spi_ctrl.v ====
// Serial command decoder and control logic of a dual low-side switch.
// Assumes SPI pins asynchronous to clk, fault inputs on clk already
// filtered, and an external pad resolving each pin from its enable.
//
// Overview of operation
// - Fault pin falls when an error is latched
// - Fault pin returns high when diagnosis cleared
// - Status pin mirrors input, inverted on error
// - Deselected: ignore clock and data, output floats
// - Select: load diagnosis, enable shifting, drive output
// - Sample on falling clock, shift out on rising
// - Deselect: execute frame, clear diagnosis if valid
// - Eight bits MSB first: code three, data five
// - Reset: shared pin is channel b status
// - Code 001 reads only; 000 does nothing
// - Output config bits 4,3 choose overload mode
// - Output config bit 2 chooses overtemp latch
// - Output config bits 1,0 choose slew rate
// - IO config bit 4 chooses status or serial
// - IO config bits 3,2 choose channel control
// - IO config bits 1,0 choose multifunction role
// - Reset command restores defaults, clears faults
// - Sleep honours only wake-up; undervoltage also wakes
// - Wake-up leaves sleep at once, full function after wake delay
// - Channel command stores serial on/off bits
// - Sleep switches outputs off, clears channel bits
// - Invalid command discarded, diagnosis kept
// - Diagnosis top two bits read high
// - Sleep keeps configuration, clears diagnosis
`timescale 1ns/1ns
`default_nettype none
`include "dsw_defines.vh"

module dsw_spi_ctrl #(
  parameter [15:0] WAKE_CYCLES = `DSW_WAKE_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Serial port pins
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire si_pin,
  // Undervoltage reset pin
  input wire uv_reset_pin,
  // Parallel channel inputs
  input wire parallel_input_ch_a,
  input wire parallel_input_ch_b,
  // Filtered fault conditions from the analog part
  input wire [1:0] diag_ch_a_in,
  input wire [1:0] diag_ch_b_in,
  input wire chan_overtemp_in,
  input wire ic_warn_in,
  // Multifunction pin a, open drain
  output reg multifunction_pin_a_out,
  output reg multifunction_pin_a_oe,
  // Multifunction pin b, serial out or open-drain status
  output reg multifunction_pin_b_out,
  output reg multifunction_pin_b_oe,
  // Sense routing
  output reg sense_of_ch_a,
  output reg sense_of_ch_b,
  // Power stage controls
  output reg channel_a_on,
  output reg channel_b_on,
  output reg overload_mode_ch_a,
  output reg overload_mode_ch_b,
  output reg overtemp_latch,
  output reg slew_slow_ch_a,
  output reg slew_slow_ch_b,
  output reg sleep_mode,
  output reg full_function
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  wire uv_s;
  wire [3:0] pin_raw;
  wire [3:0] pin_s;
  genvar g;

  assign pin_raw = {uv_reset_pin, si_pin, sclk_pin, cs_n_pin};
  assign {uv_s, si_s, sclk_s, cs_n_s} = pin_s;

  // Select idles high, every other pin idles low
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      dsw_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .rst_level(g == 0),
        .pin(pin_raw[g]),
        .level_q(pin_s[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  reg cs_n_prev_q;
  reg sclk_prev_q;
  wire cs_fall;
  wire cs_rise;
  wire sclk_fall;
  wire sclk_rise;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign cs_fall = cs_n_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_n_prev_q & cs_n_s;
  assign sclk_fall = ~cs_n_s & sclk_prev_q & ~sclk_s;
  assign sclk_rise = ~cs_n_s & ~sclk_prev_q & sclk_s;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [4:0] outcfg_q;
  reg [4:0] iocfg_q;
  reg [1:0] chan_q;
  reg [5:0] diag_q;
  reg sleep_q;
  reg [15:0] wake_cnt_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg so_q;
  reg [3:0] bit_cnt_q;
  wire waking;
  wire [2:0] cmd;
  wire [4:0] data;
  wire frame_ok;
  wire cmd_valid;
  wire diag_clear;
  assign waking = (wake_cnt_q != 16'h0000);
  assign cmd = rx_q[`DSW_CMD_MSB:`DSW_CMD_LSB];
  assign data = rx_q[4:0];
  assign frame_ok = (bit_cnt_q == `DSW_FRAME_BITS);
  // Only wake-up passes in sleep or while the wake delay runs
  assign cmd_valid = frame_ok & (cmd != `DSW_CMD_NONE) &
    ((~sleep_q & ~waking) | (cmd == `DSW_CMD_WAKE));
  assign diag_clear = cs_rise & cmd_valid;

  // ****************************************************************
  // Shift register
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      so_q <= 1'b0;
      bit_cnt_q <= 4'h0;
    end else if (cs_fall) begin
      // In sleep no diagnosis is transferred
      if (sleep_q) begin
        tx_q <= 8'h00;
        so_q <= 1'b0;
      end else begin
        tx_q <= {`DSW_DIAG_TOP, diag_q};
        so_q <= 1'b1;
      end
      bit_cnt_q <= 4'h0;
    end else begin
      if (sclk_fall) begin
        rx_q <= {rx_q[6:0], si_s};
        if (bit_cnt_q != 4'hf) begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
      if (sclk_rise) begin
        so_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Command execution
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outcfg_q <= `DSW_OUTCFG_RST;
      iocfg_q <= `DSW_IOCFG_RST;
      chan_q <= `DSW_CHAN_RST;
      sleep_q <= 1'b0;
      wake_cnt_q <= 16'h0000;
    end else if (uv_s) begin
      outcfg_q <= `DSW_OUTCFG_RST;
      iocfg_q <= `DSW_IOCFG_RST;
      chan_q <= `DSW_CHAN_RST;
      sleep_q <= 1'b0;
      wake_cnt_q <= 16'h0000;
    end else begin
      if (waking) begin
        wake_cnt_q <= wake_cnt_q - 16'h0001;
      end
      if (cs_rise && cmd_valid) begin
        case (cmd)
          `DSW_CMD_OUTCFG: begin
            outcfg_q <= data;
          end
          `DSW_CMD_IOCFG: begin
            iocfg_q <= data;
          end
          `DSW_CMD_RESET: begin
            outcfg_q <= `DSW_OUTCFG_RST;
            iocfg_q <= `DSW_IOCFG_RST;
            chan_q <= `DSW_CHAN_RST;
          end
          `DSW_CMD_SLEEP: begin
            sleep_q <= 1'b1;
            chan_q <= `DSW_CHAN_RST;
          end
          `DSW_CMD_WAKE: begin
            if (sleep_q) begin
              sleep_q <= 1'b0;
              wake_cnt_q <= WAKE_CYCLES;
            end
          end
          `DSW_CMD_CHAN: begin
            chan_q <= {data[`DSW_CH_B], data[`DSW_CH_A]};
          end
          default: begin
            chan_q <= chan_q;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Diagnosis register
  // ****************************************************************
  reg [5:0] diag_d;
  always @* begin
    diag_d = diag_q;
    // Valid frame, reset, sleep or undervoltage clear first
    if (diag_clear || uv_s) begin
      diag_d = `DSW_DIAG_CLEAR;
    end
    // A new error overwrites and wins over a clear
    if (!sleep_q && !waking) begin
      if (diag_ch_b_in != `DSW_PAIR_OK) begin
        diag_d[5:4] = diag_ch_b_in;
      end
      if (diag_ch_a_in != `DSW_PAIR_OK) begin
        diag_d[3:2] = diag_ch_a_in;
      end
      if (chan_overtemp_in) begin
        diag_d[1] = 1'b1;
      end
      if (ic_warn_in) begin
        diag_d[0] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_q <= `DSW_DIAG_CLEAR;
    end else begin
      diag_q <= diag_d;
    end
  end

  // ****************************************************************
  // Channel control
  // ****************************************************************
  reg eff_a;
  reg eff_b;
  always @* begin
    case (iocfg_q[`DSW_IO_CTRL_MSB:`DSW_IO_CTRL_LSB])
      `DSW_CTRL_PAR: begin
        eff_a = parallel_input_ch_a;
        eff_b = parallel_input_ch_b;
      end
      `DSW_CTRL_OR: begin
        eff_a = parallel_input_ch_a | chan_q[0];
        eff_b = parallel_input_ch_b | chan_q[1];
      end
      `DSW_CTRL_AND: begin
        eff_a = parallel_input_ch_a & chan_q[0];
        eff_b = parallel_input_ch_b & chan_q[1];
      end
      default: begin
        eff_a = chan_q[0];
        eff_b = chan_q[1];
      end
    endcase
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  wire err_a;
  wire err_b;
  wire err_any;
  wire spi_mode;
  wire [1:0] pin_role;
  assign err_a = (diag_ch_a_in != `DSW_PAIR_OK);
  assign err_b = (diag_ch_b_in != `DSW_PAIR_OK);
  assign err_any = (diag_q != `DSW_DIAG_CLEAR);
  assign spi_mode = iocfg_q[`DSW_IO_SPI];
  assign pin_role = iocfg_q[`DSW_IO_PIN_MSB:`DSW_IO_PIN_LSB];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multifunction_pin_a_out <= 1'b0;
      multifunction_pin_a_oe <= 1'b1;
      multifunction_pin_b_out <= 1'b0;
      multifunction_pin_b_oe <= 1'b1;
      sense_of_ch_a <= 1'b0;
      sense_of_ch_b <= 1'b0;
      channel_a_on <= 1'b0;
      channel_b_on <= 1'b0;
      overload_mode_ch_a <= 1'b0;
      overload_mode_ch_b <= 1'b0;
      overtemp_latch <= 1'b0;
      slew_slow_ch_a <= 1'b0;
      slew_slow_ch_b <= 1'b0;
      sleep_mode <= 1'b0;
      full_function <= 1'b0;
    end else begin
      multifunction_pin_a_out <= 1'b0;
      multifunction_pin_b_out <= 1'b0;
      if (sleep_q) begin
        // Status low, fault high while asleep
        multifunction_pin_a_oe <= ~spi_mode;
        multifunction_pin_b_oe <= ~spi_mode;
      end else if (!spi_mode) begin
        // Open drain pulls low for a low status level
        multifunction_pin_a_oe <= ~(parallel_input_ch_a ^ err_a);
        multifunction_pin_b_oe <= ~(parallel_input_ch_b ^ err_b);
      end else begin
        multifunction_pin_a_oe <= err_any & (pin_role == `DSW_PIN_FAULT);
        multifunction_pin_b_out <= so_q;
        multifunction_pin_b_oe <= ~cs_n_s;
      end
      sense_of_ch_a <= spi_mode & ~sleep_q & pin_role[0];
      sense_of_ch_b <= spi_mode & ~sleep_q & pin_role[1];
      channel_a_on <= eff_a & ~sleep_q & ~waking;
      channel_b_on <= eff_b & ~sleep_q & ~waking;
      overload_mode_ch_a <= outcfg_q[`DSW_OC_OVL_A];
      overload_mode_ch_b <= outcfg_q[`DSW_OC_OVL_B];
      overtemp_latch <= outcfg_q[`DSW_OC_LATCH];
      slew_slow_ch_a <= outcfg_q[`DSW_OC_SLEW_A];
      slew_slow_ch_b <= outcfg_q[`DSW_OC_SLEW_B];
      sleep_mode <= sleep_q;
      full_function <= ~sleep_q & ~waking;
    end
  end

endmodule

`default_nettype wire

// ==== dsw_spi_ctrl_checker.sv ====
// Assertion checker for the dual switch serial control block.
// Assumes binding onto dsw_spi_ctrl and sight of its ports only.
`timescale 1ns/1ns
`default_nettype none
module dsw_spi_ctrl_checker #(
  parameter [15:0] WAKE_CYCLES = 16'h00c8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Observed ports
  input wire cs_n_pin,
  input wire multifunction_pin_a_out,
  input wire multifunction_pin_a_oe,
  input wire sense_of_ch_a,
  input wire sense_of_ch_b,
  input wire channel_a_on,
  input wire channel_b_on,
  input wire overload_mode_ch_a,
  input wire overload_mode_ch_b,
  input wire overtemp_latch,
  input wire slew_slow_ch_a,
  input wire slew_slow_ch_b,
  input wire sleep_mode,
  input wire full_function
);
  // ****
  // Wake delay counter
  // ****
  wire [7:0] cfg;
  logic waking_q;
  logic [15:0] wcnt_q;
  assign cfg = {sense_of_ch_b, sense_of_ch_a, overload_mode_ch_b,
    overload_mode_ch_a, overtemp_latch, slew_slow_ch_b, slew_slow_ch_a,
    1'b0};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waking_q <= 1'b0;
      wcnt_q <= 16'h0000;
    end else begin
      if (sleep_mode) begin
        waking_q <= 1'b1;
      end else if (full_function) begin
        waking_q <= 1'b0;
      end
      if (full_function || sleep_mode) begin
        wcnt_q <= 16'h0000;
      end else begin
        wcnt_q <= wcnt_q + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_woke;
    $fell(sleep_mode);
  endsequence
  sequence s_dark;
    (!full_function)[*8];
  endsequence
  AST_PIN_A_OD: assert property ((sense_of_ch_a || sense_of_ch_b) |->
    !multifunction_pin_a_oe && !multifunction_pin_a_out)
    else $error("pin a pulled while sensing");
  AST_CFG_AFTER_CS: assert property ($changed(cfg) |->
    cs_n_pin && $past(cs_n_pin, 4)) else $error("config moved in frame");
  AST_SLEEP_AT_CS: assert property ($rose(sleep_mode) |->
    cs_n_pin && $past(cs_n_pin, 4)) else $error("sleep not at deselect");
  AST_SLEEP_HOLDS: assert property (sleep_mode && $past(sleep_mode)
    |-> $stable(cfg)) else $error("config changed in sleep");
  AST_DARK_OFF: assert property ((!full_function)[*2] |->
    !channel_a_on && !channel_b_on) else $error("channel on while idle");
  AST_FULL_AWAKE: assert property (sleep_mode |-> !full_function)
    else $error("full function in sleep");
  AST_WAKE_HOLD: assert property (s_woke |-> s_dark)
    else $error("wake delay too short");
  AST_WAKE_LEN: assert property ($rose(full_function) && waking_q |->
    wcnt_q >= WAKE_CYCLES - 2 && wcnt_q <= WAKE_CYCLES + 3)
    else $error("wake delay length off");
endmodule
bind dsw_spi_ctrl dsw_spi_ctrl_checker #(.WAKE_CYCLES(WAKE_CYCLES))
  dsw_spi_ctrl_checker_i (.clk, .rst_n, .cs_n_pin,
  .multifunction_pin_a_out, .multifunction_pin_a_oe,
  .sense_of_ch_a, .sense_of_ch_b,
  .channel_a_on, .channel_b_on, .overload_mode_ch_a, .overload_mode_ch_b,
  .overtemp_latch, .slew_slow_ch_a, .slew_slow_ch_b, .sleep_mode,
  .full_function);
`default_nettype wire

// ==== dsw_spi_master.sv ====
// Serial master model that sends frames and reads the answer word.
// Assumes the block clock for pacing; each clock phase is 5 cycles.
`timescale 1ns/1ns
`default_nettype none
module dsw_spi_master (
  // Clock
  input wire clk,
  // Serial lines
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire so
);
  // ****
  // Frame driver
  // ****
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  task automatic phase();
    repeat (5) @(negedge clk);
  endtask
  task automatic noise();
    repeat (4) begin
      sclk = ~sclk;
      si = ~si;
      phase();
    end
  endtask
  task automatic xfer(input logic [7:0] tx, input int nb,
    output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    phase();
    for (i = 0; i < nb; i++) begin
      si = tx[7 - i];
      sclk = 1'b1;
      phase();
      sclk = 1'b0;
      phase();
      rx = {rx[6:0], so};
    end
    si = 1'b0;
    phase();
    cs_n = 1'b1;
    phase();
    phase();
  endtask
endmodule
`default_nettype wire

// ==== dsw_spi_ctrl_tb.sv ====
// Self-checking bench for the dual switch serial control block.
// Assumes the master model and the bound checker alongside.
`timescale 1ns/1ns
`default_nettype none
module dsw_spi_ctrl_tb;
  // ****
  // Bench
  // ****
  logic clk, rst_n, uv, pa, pb, cot, icw, flt_q;
  logic [1:0] da, db;
  logic [7:0] rx, d, c0;
  integer seed, miscompares, tests_run, i, k, n;
  wire cs_n, sclk, si, so, a_out, a_oe, b_out, b_oe, s_a, s_b;
  wire on_a, on_b, ov_a, ov_b, ot, sl_a, sl_b, slp, ff;
  wire [7:0] cfg;
  assign cfg = {1'b0, s_b, s_a, ov_b, ov_a, ot, sl_b, sl_a};
  assign so = b_oe ? b_out : flt_q;
  dsw_spi_master dsw_spi_master_i (.clk(clk), .cs_n(cs_n),
    .sclk(sclk), .si(si), .so(so));
  dsw_spi_ctrl #(.WAKE_CYCLES(16'h00c8)) dsw_spi_ctrl_i (.clk(clk),
    .rst_n(rst_n), .cs_n_pin(cs_n), .sclk_pin(sclk), .si_pin(si),
    .uv_reset_pin(uv), .parallel_input_ch_a(pa), .parallel_input_ch_b(pb),
    .diag_ch_a_in(da), .diag_ch_b_in(db), .chan_overtemp_in(cot),
    .ic_warn_in(icw), .multifunction_pin_a_out(a_out),
    .multifunction_pin_a_oe(a_oe), .multifunction_pin_b_out(b_out),
    .multifunction_pin_b_oe(b_oe), .sense_of_ch_a(s_a),
    .sense_of_ch_b(s_b), .channel_a_on(on_a), .channel_b_on(on_b),
    .overload_mode_ch_a(ov_a), .overload_mode_ch_b(ov_b),
    .overtemp_latch(ot), .slew_slow_ch_a(sl_a), .slew_slow_ch_b(sl_b),
    .sleep_mode(slp), .full_function(ff));
  function automatic logic exp_on(input logic [1:0] m, input logic p,
    input logic s);
    case (m)
      2'h0: exp_on = p;
      2'h1: exp_on = p | s;
      2'h2: exp_on = p & s;
      default: exp_on = s;
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [4:0] dd);
    dsw_spi_master_i.xfer({c, dd}, 8, rx);
  endtask
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) flt_q <= (flt_q === 1'b1) ? 1'b0 : 1'b1;
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    {rst_n, uv, pa, pb, cot, icw} = 6'h00;
    {da, db} = 4'hf;
    seed = 6569;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("status b", 8'h01, b_oe);
    pb = 1'b1;
    settle();
    check("status b", 8'h00, b_oe);
    db = 2'h1;
    settle();
    check("status err", 8'h01, b_oe);
    db = 2'h3;
    check("defaults", 8'h00, cfg);
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h1f : $random(seed);
      cmd(3'h2, d[4:0]);
      check("out cfg", {3'h0, d[4:0]}, cfg);
    end
    cmd(3'h1, ~d[4:0]);
    cmd(3'h0, ~d[4:0]);
    dsw_spi_master_i.xfer({3'h2, ~d[4:0]}, 7, rx);
    check("out cfg kept", {3'h0, d[4:0]}, cfg);
    for (i = 0; i < 4; i++) begin
      cmd(3'h3, {1'b0, i[1:0], 2'h0});
      for (k = 0; k < 4; k++) begin
        d = $random(seed);
        cmd(3'h7, {d[1:0], 3'h0});
        pa = d[2];
        pb = d[3];
        settle();
        check("chan on", {exp_on(i[1:0], pb, d[1]),
          exp_on(i[1:0], pa, d[0])}, {on_b, on_a});
      end
    end
    for (i = 1; i < 4; i++) begin
      cmd(3'h3, {3'h4, i[1:0]});
      check("sense", i[7:0], {s_b, s_a});
    end
    cmd(3'h3, 5'h10);
    dsw_spi_master_i.noise();
    check("so float", 8'h00, b_oe);
    cmd(3'h1, 5'h00);
    check("fault pin", 8'h00, a_oe);
    da = 2'h1;
    icw = 1'b1;
    settle();
    check("fault pin", 8'h01, a_oe);
    {da, icw} = 3'h6;
    cmd(3'h0, 5'h00);
    check("diag word", 8'hf5, rx);
    check("fault kept", 8'h01, a_oe);
    dsw_spi_master_i.xfer(8'h20, 7, rx);
    check("fault kept", 8'h01, a_oe);
    cmd(3'h1, 5'h00);
    check("diag word", 8'hf5, rx);
    check("fault pin", 8'h00, a_oe);
    cmd(3'h1, 5'h00);
    check("diag clear", 8'hfc, rx);
    cmd(3'h3, 5'h1c);
    cmd(3'h7, 5'h18);
    check("chan on", 8'h03, {on_b, on_a});
    c0 = cfg;
    cmd(3'h5, 5'h00);
    check("sleep", 8'h04, {slp, on_b, on_a});
    cmd(3'h2, ~c0[4:0]);
    check("cfg in sleep", c0, cfg);
    cmd(3'h6, 5'h00);
    cmd(3'h7, 5'h18);
    check("awake", 8'h00, {slp, on_b, on_a});
    n = 0;
    while (ff !== 1'b1) begin
      n++;
      if (n > 400) begin
        miscompares++;
        conclude();
      end
      @(negedge clk);
    end
    settle();
    check("after wake", {c0[7:0]}, cfg);
    check("chan off", 8'h00, {on_b, on_a});
    cmd(3'h4, 5'h00);
    check("reset cmd", 8'h00, cfg);
    cmd(3'h2, 5'h1f);
    uv = 1'b1;
    settle();
    uv = 1'b0;
    settle();
    check("uv reset", 8'h00, cfg);
    conclude();
  end
endmodule
`default_nettype wire
